// [logic/aotf_iir.sv]
// Per-bank IIR offset estimator with power-of-two coefficient.
`timescale 1ns/100ps
`default_nettype none
module aotf_iir (
   input  wire logic i_clk,
   input  wire logic i_srst,
   aotf_iir_if.iir   iif
);

   aotf_pkg::aotf_iir_t st_reg;
   aotf_pkg::aotf_iir_t st_next;
   logic [33:0]         sum_w;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   // ------------------------------------------------------------------
   // Estimate update and bank readout.
   // ------------------------------------------------------------------

   // One step moves the estimate toward the sample by a shifted error.
   always_comb begin
      logic [31:0] xe;
      logic [31:0] err;
      xe      = {iif.x, 16'h0000};
      err     = xe - st_reg.est[iif.bank];
      st_next = st_reg;
      if (i_srst || iif.clr) begin
         st_next = '0;
      end else if (iif.upd) begin
         // RULE_15 shift update
         st_next.est[iif.bank] = st_reg.est[iif.bank] +
                                 32'($signed(err) >>> iif.shift);
      end
   end

   // Sum of all bank estimates for the common offset.
   always_comb begin
      sum_w = '0;
      for (int i = 0; i < aotf_pkg::NUM_BANKS; i++) begin
         sum_w = sum_w + {{2{st_reg.est[i][31]}}, st_reg.est[i]};
      end
   end

   assign iif.est_bank = st_reg.est[iif.bank];
   assign iif.est_mean = sum_w[33:2];

   // Registers the estimator state.
   always_ff @(posedge i_clk) begin
      st_reg <= st_next;
   end

   a_iir_step: assert property ( // RULE_15
      (iif.upd && !iif.clr) |=> (st_reg.est[$past(iif.bank)] ==
         $past(st_reg.est[iif.bank] + 32'($signed({iif.x, 16'h0000} -
         st_reg.est[iif.bank]) >>> iif.shift))))
      else $error("Estimate step does not match the shifted error.");

   a_iir_hold: assert property ( // RULE_10
      (!iif.upd && !iif.clr) |=> $stable(st_reg))
      else $error("Estimate moved without an update.");

endmodule
`default_nettype wire

// [logic/aotf_iir_if.sv]
// Link between the trim datapath and the per-bank offset estimator.
`timescale 1ns/100ps
`default_nettype none
interface aotf_iir_if;
   logic        upd;
   logic        clr;
   logic [1:0]  bank;
   logic [15:0] x;
   logic [4:0]  shift;
   logic [31:0] est_bank;
   logic [31:0] est_mean;

   modport ctl (output upd, clr, bank, x, shift, input est_bank, est_mean);
   modport iir (input upd, clr, bank, x, shift, output est_bank, est_mean);
endinterface
`default_nettype wire

// [logic/aotf_pkg.sv]
// Constants, types and register map of the offset trim and filter block.
`default_nettype none
package aotf_pkg;

   // ------------------------------------------------------------------
   // Register indices; byte address is four times the index.
   // ------------------------------------------------------------------
   localparam logic [9:0] IDX_TRIM_A   = 10'h092;
   localparam logic [9:0] IDX_TRIM_B   = 10'h094;
   localparam logic [9:0] IDX_FILT_A   = 10'h097;
   localparam logic [9:0] IDX_FILT_B   = 10'h098;
   localparam logic [9:0] IDX_CAL_CTRL = 10'h099;
   localparam logic [9:0] IDX_STATUS   = 10'h09A;

   // ------------------------------------------------------------------
   // Field positions and reset values.
   // ------------------------------------------------------------------
   localparam int         TRIM_W        = 12;
   localparam logic [0:0] FILT_A_RST    = 1'h0;
   localparam logic [7:0] FILT_B_RST    = 8'h33;
   localparam logic [3:0] CAL_CTRL_RST  = 4'h0;
   localparam int         CTRL_OS       = 0;
   localparam int         CTRL_BG       = 1;
   localparam int         CTRL_BGOS     = 2;
   localparam int         CTRL_FILT     = 3;
   localparam logic [3:0] BW_MIN        = 4'h1;
   localparam logic [3:0] BW_MAX        = 4'h5;
   localparam logic [4:0] BW_SHIFT_BASE = 5'h09;
   localparam int         NUM_BANKS     = 4;
   localparam int         FRAC_W        = 16;
   localparam int         SOAK_CNT_W    = 24;

   // ------------------------------------------------------------------
   // Soak sequencer states, one-hot.
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_SOAK = 3'h2,
      ST_LIVE = 3'h4
   } aotf_state_t;

   // Complete state of the top module.
   typedef struct packed {
      logic [11:0]           trim_a;
      logic [11:0]           trim_b;
      logic                  keep_dc;
      logic [3:0]            bw;
      logic [3:0]            soak;
      logic [3:0]            cal_ctrl;
      logic [15:0]           rdata;
      logic                  out_valid;
      logic [15:0]           out_data;
      aotf_state_t           state;
      logic [SOAK_CNT_W-1:0] soak_cnt;
      logic                  online;
      logic                  soaking;
   } aotf_main_t;

   // Complete state of the estimator.
   typedef struct packed {
      logic [NUM_BANKS-1:0][31:0] est;
   } aotf_iir_t;

endpackage
`default_nettype wire

// [logic/aotf_top.sv]
// Offset trim, offset filter and soak sequencer for the third converter core.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// (RULE_01) Add 12-bit input A trim to samples taken on input A; top bits zero.
// (RULE_02) Add a separate 12-bit input B trim to samples taken on input B.
// (RULE_03) Trims load the factory value at reset; readable and writable afterwards.
// (RULE_04) Software never writes trims during a foreground calibration.
// (RULE_05) Software never writes trims while both background enables are set.
// (RULE_06) Offset cal without background: read trims only after foreground done.
// (RULE_07) With both background enables set, read trims only while halted.
// (RULE_08) Keep-DC set: remove only offset mismatch between banks.
// (RULE_09) Keep-DC clear, the reset value: remove all offsets, stripping DC.
// (RULE_10) Filter acts only when enabled; its settings do nothing otherwise.
// (RULE_11) Bandwidth codes 1 to 5 pick 2^-10 to 2^-14; others reserved.
// (RULE_12) Soak code sets settling after connection to a freshly calibrated core.
// (RULE_13) After soak the core goes online through the IIR filter.
// (RULE_14) Software programs soak equal to bandwidth.
// (RULE_15) Estimate grows by coefficient times error, done as arithmetic shift.
module aotf_top #(
   parameter int SOAK_BASE_LOG2 = 10
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic [11:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output var  logic [15:0] o_rdata,
   input  wire logic [11:0] i_factory_trim_a,
   input  wire logic [11:0] i_factory_trim_b,
   input  wire logic        i_fg_cal_busy,
   input  wire logic        i_foreground_cal_done_flag,
   input  wire logic        i_calibration_halted_flag,
   input  wire logic        i_core_calibrated,
   input  wire logic        i_sample_valid,
   input  wire logic        i_sample_input_b,
   input  wire logic [1:0]  i_sample_bank,
   input  wire logic [11:0] i_sample,
   output var  logic        o_out_valid,
   output var  logic [15:0] o_out_data,
   output var  logic        o_core_online,
   output var  logic        o_soaking,
   output var  logic [3:0]  o_cal_ctrl
);

   aotf_pkg::aotf_main_t st_reg;
   aotf_pkg::aotf_main_t st_next;
   aotf_iir_if           iif ();

   logic [15:0]                     corr_w;
   logic [15:0]                     est_w;
   logic [15:0]                     mean_w;
   logic                            filt_en_w;
   logic                            bg_en_w;
   logic                            bw_ok_w;
   logic [3:0]                      soak_code_w;
   logic [aotf_pkg::SOAK_CNT_W-1:0] soak_lim_w;
   logic                            hit_w;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   // ------------------------------------------------------------------
   // Estimator instance.
   // ------------------------------------------------------------------

   // Holds one running offset estimate per interleaved bank.
   aotf_iir u_iir (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .iif    (iif)
   );

   // ------------------------------------------------------------------
   // Datapath helpers.
   // ------------------------------------------------------------------

   // Trim selection follows the input the core is sampling.
   // The sum is kept at 16 bits so a full-scale sample plus the largest
   // trim never wraps.
   // RULE_01 input A trim
   // RULE_02 input B trim
   assign corr_w = 16'(i_sample) +
                   16'(i_sample_input_b ? st_reg.trim_b : st_reg.trim_a);

   // Integer parts of the bank estimate and the common estimate.
   assign est_w  = iif.est_bank[31:aotf_pkg::FRAC_W];
   assign mean_w = iif.est_mean[31:aotf_pkg::FRAC_W];

   // Enables and bandwidth code checks.
   assign filt_en_w = st_reg.cal_ctrl[aotf_pkg::CTRL_FILT];
   assign bg_en_w   = st_reg.cal_ctrl[aotf_pkg::CTRL_BG];
   // RULE_11 reserved codes
   assign bw_ok_w   = (st_reg.bw >= aotf_pkg::BW_MIN) && (st_reg.bw <= aotf_pkg::BW_MAX);

   // A reserved soak code falls back to the longest soak.
   assign soak_code_w = ((st_reg.soak >= aotf_pkg::BW_MIN) &&
                         (st_reg.soak <= aotf_pkg::BW_MAX)) ? st_reg.soak
                                                            : aotf_pkg::BW_MAX;
   // With the default base the shortest legal soak is 1024 samples; a
   // smaller base shortens every soak for quick simulation.
   // RULE_12 soak length
   assign soak_lim_w  = aotf_pkg::SOAK_CNT_W'(1) <<
                        (SOAK_BASE_LOG2 + int'(soak_code_w) - 1);

   // Register address hit: aligned word only.
   // Unaligned accesses are dropped rather than rounded down, so a stray
   // byte address can never alias onto a trim.
   assign hit_w = (i_addr[1:0] == 2'h0);

   // ------------------------------------------------------------------
   // Estimator controls.
   // ------------------------------------------------------------------

   // Updates run only with the filter on and a legal bandwidth code.
   // RULE_10 filter gating
   assign iif.upd   = i_sample_valid && filt_en_w && bw_ok_w;
   assign iif.bank  = i_sample_bank;
   assign iif.x     = corr_w;
   // RULE_11 coefficient select
   assign iif.shift = aotf_pkg::BW_SHIFT_BASE + 5'(st_reg.bw);
   // A freshly calibrated core restarts its estimates from zero.
   // Clearing only from idle lets a live re-calibration keep settled estimates.
   assign iif.clr   = (st_reg.state == aotf_pkg::ST_IDLE) && i_core_calibrated &&
                      filt_en_w && bg_en_w;

   // ------------------------------------------------------------------
   // Next-state logic.
   // ------------------------------------------------------------------

   // Register file, output datapath and soak sequencer.
   always_comb begin
      st_next          = st_reg;
      st_next.rdata    = 16'h0000;
      st_next.out_valid = i_sample_valid;

      // Register writes; software keeps to the calibration access windows.
      // Hardware never blocks a trim write; a write that lands during a
      // calibration simply races the calibration engine for the value.
      // RULE_04 write window
      // RULE_05 write window
      if (i_wr && hit_w) begin
         case (i_addr[11:2])
            aotf_pkg::IDX_TRIM_A:   st_next.trim_a   = i_wdata[11:0];
            aotf_pkg::IDX_TRIM_B:   st_next.trim_b   = i_wdata[11:0];
            aotf_pkg::IDX_FILT_A:   st_next.keep_dc  = i_wdata[0];
            aotf_pkg::IDX_FILT_B: begin
               st_next.bw   = i_wdata[7:4];
               st_next.soak = i_wdata[3:0];
            end
            aotf_pkg::IDX_CAL_CTRL: st_next.cal_ctrl = i_wdata[3:0];
            default:                st_next.trim_a   = st_reg.trim_a;
         endcase
      end

      // Register reads; unmapped words and reserved bits read as zero.
      // RULE_06 read window
      // RULE_07 read window
      if (i_rd && hit_w) begin
         case (i_addr[11:2])
            aotf_pkg::IDX_TRIM_A:   st_next.rdata = {4'h0, st_reg.trim_a};
            aotf_pkg::IDX_TRIM_B:   st_next.rdata = {4'h0, st_reg.trim_b};
            aotf_pkg::IDX_FILT_A:   st_next.rdata = {15'h0000, st_reg.keep_dc};
            aotf_pkg::IDX_FILT_B:   st_next.rdata = {8'h00, st_reg.bw, st_reg.soak};
            aotf_pkg::IDX_CAL_CTRL: st_next.rdata = {12'h000, st_reg.cal_ctrl};
            aotf_pkg::IDX_STATUS: begin
               st_next.rdata = {11'h000, st_reg.online, st_reg.soaking,
                                i_calibration_halted_flag,
                                i_foreground_cal_done_flag, i_fg_cal_busy};
            end
            default:                st_next.rdata = 16'h0000;
         endcase
      end

      // Output sample: bypass, full offset removal or mismatch-only removal.
      // The estimates used here are those from before this sample's update,
      // so the correction lags the estimator by exactly one sample.
      if (!filt_en_w) begin
         // RULE_10 bypass
         st_next.out_data = corr_w;
      end else if (st_reg.keep_dc) begin
         // RULE_08 mismatch only
         st_next.out_data = corr_w - (est_w - mean_w);
      end else begin
         // RULE_09 strip DC
         st_next.out_data = corr_w - est_w;
      end

      // Soak sequencer.
      // The soak counts valid samples, not clocks, so an idle input stretches it.
      // Re-calibration while live restarts the soak but keeps the estimates.
      case (st_reg.state)
         aotf_pkg::ST_IDLE: begin
            // RULE_12 soak start
            if (i_core_calibrated && filt_en_w && bg_en_w) begin
               st_next.state    = aotf_pkg::ST_SOAK;
               st_next.soak_cnt = '0;
               st_next.online   = 1'b0;
               st_next.soaking  = 1'b1;
            end
         end
         aotf_pkg::ST_SOAK: begin
            if (!(filt_en_w && bg_en_w)) begin
               st_next.state   = aotf_pkg::ST_IDLE;
               st_next.online  = 1'b1;
               st_next.soaking = 1'b0;
            end else if (i_sample_valid) begin
               if (st_reg.soak_cnt >= soak_lim_w - 1'b1) begin
                  // RULE_13 go online
                  st_next.state   = aotf_pkg::ST_LIVE;
                  st_next.online  = 1'b1;
                  st_next.soaking = 1'b0;
               end else begin
                  st_next.soak_cnt = st_reg.soak_cnt + 1'b1;
               end
            end
         end
         aotf_pkg::ST_LIVE: begin
            // Leaving background filtering returns to plain operation.
            if (!(filt_en_w && bg_en_w)) begin
               st_next.state = aotf_pkg::ST_IDLE;
            end else if (i_core_calibrated) begin
               st_next.state    = aotf_pkg::ST_SOAK;
               st_next.soak_cnt = '0;
               st_next.online   = 1'b0;
               st_next.soaking  = 1'b1;
            end
         end
         default: begin
            st_next.state   = aotf_pkg::ST_IDLE;
            st_next.online  = 1'b1;
            st_next.soaking = 1'b0;
         end
      endcase

      // Synchronous reset; trims take the factory value.
      // Estimates are cleared inside the estimator by the same reset.
      if (i_srst) begin
         // RULE_03 factory load
         st_next           = '0;
         st_next.trim_a    = i_factory_trim_a;
         st_next.trim_b    = i_factory_trim_b;
         st_next.keep_dc   = aotf_pkg::FILT_A_RST;
         st_next.bw        = aotf_pkg::FILT_B_RST[7:4];
         st_next.soak      = aotf_pkg::FILT_B_RST[3:0];
         st_next.cal_ctrl  = aotf_pkg::CAL_CTRL_RST;
         st_next.state     = aotf_pkg::ST_IDLE;
         st_next.online    = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // State register and outputs.
   // ------------------------------------------------------------------

   // Registers the whole block state.
   always_ff @(posedge i_clk) begin
      st_reg <= st_next;
   end

   // Every output is taken straight from the state register.
   assign o_rdata       = st_reg.rdata;
   assign o_out_valid   = st_reg.out_valid;
   assign o_out_data    = st_reg.out_data;
   assign o_core_online = st_reg.online;
   assign o_soaking     = st_reg.soaking;
   assign o_cal_ctrl    = st_reg.cal_ctrl;

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------

   a_trim_a_path: assert property ( // RULE_01
      (i_sample_valid && !i_sample_input_b && !filt_en_w) |=>
         (o_out_valid && o_out_data == 16'($past(i_sample)) +
          16'($past(st_reg.trim_a))))
      else $error("Input A sample lacks its trim.");

   a_trim_b_path: assert property ( // RULE_02
      (i_sample_valid && i_sample_input_b && !filt_en_w) |=>
         (o_out_data == 16'($past(i_sample)) + 16'($past(st_reg.trim_b))))
      else $error("Input B sample lacks its trim.");

   a_trim_reset: assert property ( // RULE_03
      $fell(i_srst) |-> (st_reg.trim_a == $past(i_factory_trim_a) &&
                         st_reg.trim_b == $past(i_factory_trim_b)))
      else $error("Trim did not load the factory value.");

   a_trim_readback: assert property ( // RULE_01
      (i_rd && i_addr == {aotf_pkg::IDX_TRIM_A, 2'h0}) |=>
         (o_rdata == {4'h0, $past(st_reg.trim_a)}))
      else $error("Trim read back wrong or reserved bits set.");

   a_keep_dc: assert property ( // RULE_08
      (i_sample_valid && filt_en_w && st_reg.keep_dc) |=>
         (o_out_data == $past(corr_w) - ($past(est_w) - $past(mean_w))))
      else $error("Mismatch-only removal wrong.");

   a_strip_dc: assert property ( // RULE_09
      (i_sample_valid && filt_en_w && !st_reg.keep_dc) |=>
         (o_out_data == $past(corr_w) - $past(est_w)))
      else $error("Full offset removal wrong.");

   // The sequencer may still be busy in the cycle the enable drops.
   a_filter_off: assert property ( // RULE_10
      !filt_en_w |-> (!iif.upd ##1 (st_reg.state == aotf_pkg::ST_IDLE)))
      else $error("Filter active while disabled.");

   a_bw_code: assert property ( // RULE_11
      iif.upd |-> (bw_ok_w && iif.shift == 5'(st_reg.bw) + 5'h09))
      else $error("Coefficient not taken from a legal code.");

   a_soak_start: assert property ( // RULE_12
      (st_reg.state == aotf_pkg::ST_IDLE && i_core_calibrated && filt_en_w &&
       bg_en_w) |=> (o_soaking && !o_core_online))
      else $error("Soak did not start.");

   a_go_online: assert property ( // RULE_13
      (o_soaking && filt_en_w && bg_en_w && i_sample_valid &&
       st_reg.soak_cnt == soak_lim_w - 1'b1) |=> (o_core_online && !o_soaking))
      else $error("Core not online after soak.");

   // ------------------------------------------------------------------
   // Register and sequencer checks.
   // ------------------------------------------------------------------

   // Input B trim reads back with its reserved bits clear.
   a_trim_b_readback: assert property ( // RULE_02
      (i_rd && i_addr == {aotf_pkg::IDX_TRIM_B, 2'h0}) |=>
         (o_rdata == {4'h0, $past(st_reg.trim_b)}))
      else $error("Input B trim read back wrong.");

   // Software may overwrite the factory trim after reset, outside the calibration windows.
   a_trim_write: assert property ( // RULE_03
      (i_wr && i_addr == {aotf_pkg::IDX_TRIM_B, 2'h0}) |=>
         (st_reg.trim_b == $past(i_wdata[11:0])))
      else $error("Input B trim write was lost.");

   // Reserved bandwidth codes never update the estimates; a clear still zeroes them.
   a_bw_reserved: assert property ( // RULE_11
      !bw_ok_w |-> !iif.upd)
      else $error("Estimate updated with a reserved bandwidth code.");

   // Losing either enable ends the soak and restores the core.
   a_soak_abort: assert property ( // RULE_12
      (o_soaking && !(filt_en_w && bg_en_w)) |=> (o_core_online && !o_soaking))
      else $error("Soak kept running without both enables.");

endmodule
`default_nettype wire

// [tb/aotf_top_tb.sv]
// Self-checking testbench of the offset trim and filter block.
`timescale 1ns/100ps
`default_nettype none
module aotf_top_tb;
   typedef struct packed {
      logic        ib;
      logic [1:0]  bank;
      logic [11:0] s;
      logic [15:0] exp;
   } aotf_row_t;

   logic        i_clk = 1'b0;
   logic        i_srst = 1'b1;
   logic [11:0] i_addr = 12'h000;
   logic [15:0] i_wdata = 16'h0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [11:0] i_sample = 12'h000;
   logic [1:0]  i_sample_bank = 2'h0;
   logic        i_sample_input_b = 1'b0;
   logic        i_sample_valid = 1'b0;
   logic        i_core_calibrated = 1'b0;
   logic        i_fg_cal_busy = 1'b0;
   logic        i_done = 1'b1;
   logic        i_halted = 1'b0;
   logic [15:0] o_rdata;
   logic [15:0] o_out_data;
   logic        o_out_valid;
   logic        o_core_online;
   logic        o_soaking;
   logic [3:0]  o_cal_ctrl;
   int          n_fail = 0;
   int          num_checks = 0;
   int          cycles = 0;
   aotf_row_t   rows [4];

   // Half period of 2.5 ns gives the 200 MHz clock.
   always #2.5 i_clk = ~i_clk;

   aotf_top #(.SOAK_BASE_LOG2(2)) aotf_top_i (
      .i_clk                      (i_clk),
      .i_srst                     (i_srst),
      .i_addr                     (i_addr),
      .i_wdata                    (i_wdata),
      .i_wr                       (i_wr),
      .i_rd                       (i_rd),
      .o_rdata                    (o_rdata),
      .i_factory_trim_a           (12'h123),
      .i_factory_trim_b           (12'h456),
      .i_fg_cal_busy              (i_fg_cal_busy),
      .i_foreground_cal_done_flag (i_done),
      .i_calibration_halted_flag  (i_halted),
      .i_core_calibrated          (i_core_calibrated),
      .i_sample_valid             (i_sample_valid),
      .i_sample_input_b           (i_sample_input_b),
      .i_sample_bank              (i_sample_bank),
      .i_sample                   (i_sample),
      .o_out_valid                (o_out_valid),
      .o_out_data                 (o_out_data),
      .o_core_online              (o_core_online),
      .o_soaking                  (o_soaking),
      .o_cal_ctrl                 (o_cal_ctrl)
   );

   // Compares one value and counts the outcome.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   // One-cycle register read; data stands in the following cycle.
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   // Sends one sample and returns the corrected output of the next cycle.
   task automatic smp(input logic ib, input logic [1:0] b, input logic [11:0] s,
                      output logic [15:0] d);
      @(posedge i_clk);
      i_sample_valid <= 1'b1;
      i_sample_input_b <= ib;
      i_sample_bank <= b;
      i_sample <= s;
      @(posedge i_clk);
      i_sample_valid <= 1'b0;
      #1;
      chk({15'h0000, o_out_valid}, 16'h0001);
      d = o_out_data;
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         finish_test();
      end
   end

   initial begin
      logic [15:0] d;
      rows[0] = '{1'b0, 2'h0, 12'h100, 16'h0BBC};
      rows[1] = '{1'b1, 2'h1, 12'h100, 16'h0110};
      rows[2] = '{1'b0, 2'h2, 12'hFFF, 16'h1ABB};
      rows[3] = '{1'b1, 2'h3, 12'h000, 16'h0010};
      repeat (6) @(posedge i_clk);
      i_srst <= 1'b0;
      #1;
      chk({9'h000, o_cal_ctrl, o_out_valid, o_soaking, o_core_online}, 16'h0001);
      chk(o_rdata, 16'h0000);
      rd(12'h248, d); chk(d, 16'h0123);
      rd(12'h250, d); chk(d, 16'h0456);
      rd(12'h25C, d); chk(d, 16'h0000);
      rd(12'h260, d); chk(d, 16'h0033);
      $display("reset values done");
      wr(12'h248, 16'hFABC);
      wr(12'h250, 16'h0010);
      wr(12'h249, 16'h0555);
      rd(12'h248, d); chk(d, 16'h0ABC);
      rd(12'h400, d); chk(d, 16'h0000);
      // keep-DC without enable has no effect
      wr(12'h25C, 16'h0001);
      foreach (rows[k]) begin
         smp(rows[k].ib, rows[k].bank, rows[k].s, d);
         chk(d, rows[k].exp);
      end
      $display("trim rows done");
      wr(12'h248, 16'h0000);
      wr(12'h25C, 16'h0000);
      wr(12'h260, 16'h0011);
      wr(12'h264, 16'h0008);
      smp(1'b0, 2'h0, 12'h800, d); chk(d, 16'h0800);
      smp(1'b0, 2'h0, 12'h800, d); chk(d, 16'h07FE);
      // keep-DC subtracts only the bank mismatch
      wr(12'h25C, 16'h0001);
      smp(1'b0, 2'h0, 12'h800, d); chk(d, 16'h07FD);
      wr(12'h25C, 16'h0000);
      wr(12'h260, 16'h0003);
      smp(1'b0, 2'h2, 12'h800, d); chk(d, 16'h0800);
      smp(1'b0, 2'h2, 12'h800, d); chk(d, 16'h0800);
      $display("filter done");
      // soak equals bandwidth; no trim writes meanwhile
      wr(12'h260, 16'h0022);
      wr(12'h264, 16'h000E);
      #1;
      chk({12'h000, o_cal_ctrl}, 16'h000E);
      @(posedge i_clk);
      i_core_calibrated <= 1'b1;
      @(posedge i_clk);
      i_core_calibrated <= 1'b0;
      #1;
      chk({14'h0000, o_soaking, o_core_online}, 16'h0002);
      // online after eight samples for soak code 2
      for (int k = 1; k <= 8; k++) begin
         smp(1'b0, 2'h1, 12'h010, d);
         chk({14'h0000, o_soaking, o_core_online},
             (k == 8) ? 16'h0001 : 16'h0002);
      end
      @(posedge i_clk);
      i_halted <= 1'b1;
      rd(12'h248, d); chk(d, 16'h0000);
      @(posedge i_clk);
      i_core_calibrated <= 1'b1;
      @(posedge i_clk);
      i_core_calibrated <= 1'b0;
      #1;
      chk({14'h0000, o_soaking, o_core_online}, 16'h0002);
      // dropping the background enable aborts the soak
      wr(12'h264, 16'h0008);
      @(posedge i_clk);
      #1;
      chk({14'h0000, o_soaking, o_core_online}, 16'h0001);
      $display("soak done");
      // status shows busy and done flags
      // no trim write while the foreground calibration runs
      @(posedge i_clk);
      i_fg_cal_busy <= 1'b1;
      i_halted <= 1'b0;
      rd(12'h268, d); chk(d, 16'h0013);
      $display("status done");
      finish_test();
   end
endmodule
`default_nettype wire
